// ===== src/pmcg_defs.vh
// Constants shared by the power mode and clock gating controller
`ifndef PMCG_DEFS_VH
`define PMCG_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMCG_OFS_CTRL 12'h000
`define PMCG_OFS_STOPIDLE 12'h004
`define PMCG_OFS_STATUS 12'h008

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PMCG_CTRL_RATIO_LSB 0
`define PMCG_CTRL_RATIO_MSB 2
`define PMCG_CTRL_DOZE 3
`define PMCG_CTRL_SRC_LSB 4
`define PMCG_CTRL_SRC_MSB 6
`define PMCG_CTRL_SWREQ 7
`define PMCG_CTRL_SWDT 8

// ----------------------------------------
// Status register fields (write one to clear the flags)
// ----------------------------------------
`define PMCG_STAT_STATE_LSB 0
`define PMCG_STAT_STATE_MSB 2
`define PMCG_STAT_SRC_LSB 3
`define PMCG_STAT_SRC_MSB 5
`define PMCG_STAT_WSLEEP 6
`define PMCG_STAT_WIDLE 7
`define PMCG_STAT_WDTWAKE 8

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define PMCG_SRC_FRC 3'h0
`define PMCG_SRC_FRCPLL 3'h1
`define PMCG_SRC_PRI 3'h2
`define PMCG_SRC_PRIPLL 3'h3
`define PMCG_SRC_SEC 3'h4
`define PMCG_SRC_LOW_POWER_RC_CLOCK 3'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMCG_OST_CYCLES 1024

`endif

// ===== src/pmcg_doze_div.v
// Doze divider producing the processor clock enable
`timescale 1ns/10ps
module pmcg_doze_div
#(
  parameter CW = 7
)
(
  input wire pclk,
  input wire presetn,
  input wire [2:0] ratio,
  output reg tick
);

  // ----------------------------------------
  // Counter and latched limit
  // ----------------------------------------
  reg [CW-1:0] cnt; // Cycles since last tick
  reg [CW-1:0] limit; // Active ratio minus one

  // Ratio is only taken at a wrap so no enable pulse is ever cut short
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= {CW{1'b0}};
      limit <= {CW{1'b0}};
      tick <= 1'b1;
    end
    else if (cnt >= limit)
    begin
      cnt <= {CW{1'b0}};
      limit <= (({{(CW-1){1'b0}}, 1'b1}) << ratio) - {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule // pmcg_doze_div

// ===== src/pmcg_ost.v
// Oscillator start-up counter
`timescale 1ns/10ps
`include "pmcg_defs.vh"
module pmcg_ost
#(
  parameter COUNT = `PMCG_OST_CYCLES
)
(
  input wire pclk,
  input wire presetn,
  input wire start,
  output reg done
);

  // ----------------------------------------
  // Count oscillator cycles after a restart
  // ----------------------------------------
  reg [10:0] cnt; // Room for the full count
  reg busy; // Counting in progress

  // A fresh start always restarts the count from zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 11'h000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      cnt <= 11'h000;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      cnt <= cnt + 11'h001;
      if (cnt == COUNT[10:0] - 11'h001)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule // pmcg_ost

// ===== src/pmcg_top.v
// Power mode controller with clock gating and APB registers
`timescale 1ns/10ps
`include "pmcg_defs.vh"
module pmcg_top
#(
  parameter NPER = 8,
  parameter OST_COUNT = `PMCG_OST_CYCLES
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire power_save_instruction_exec,
  input wire power_save_instruction_idle,
  input wire irq_wake,
  input wire wdt_timeout,
  input wire wdt_en_cfg,
  input wire clock_failure_monitor_en_cfg,
  input wire bor_en_cfg,
  input wire [2:0] cfg_clk_src,
  output reg cpu_clk_en,
  output reg sys_clk_en,
  output reg [NPER-1:0] periph_clk_en,
  output reg ext_periph_en,
  output reg osc_en,
  output reg [2:0] clk_src_sel,
  output reg clock_failure_monitor_active,
  output reg low_power_rc_clock_run,
  output reg bor_active,
  output reg wdt_clear,
  output reg wdt_reset_req,
  output reg cpu_resume
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_OST = 3'h3;
  localparam ST_SWOFF = 3'h4;
  localparam ST_SWON = 3'h5;

  // Sources that run from a crystal need a start-up wait
  function needs_ost;
    input [2:0] src;
    begin
      needs_ost = (src == `PMCG_SRC_PRI) || (src == `PMCG_SRC_PRIPLL) || (src == `PMCG_SRC_SEC);
    end
  endfunction

  // Codes above the last source are not permissible
  function src_ok;
    input [2:0] src;
    begin
      src_ok = (src <= `PMCG_SRC_LOW_POWER_RC_CLOCK);
    end
  endfunction

  // ----------------------------------------
  // Registers and internal signals
  // ----------------------------------------
  reg [2:0] state; // Power state
  reg [2:0] next_state; // Power state to come
  reg [2:0] doze_ratio; // Doze ratio code
  reg doze_en; // Doze mode on
  reg [2:0] sw_src; // Requested source
  reg sw_pend; // Switch requested, not yet taken
  reg swdt; // Software watchdog enable
  reg [NPER-1:0] stop_idle; // Stop-in-idle bits
  reg boot_load; // Configuration source not yet loaded
  reg flag_wsleep; // Woke from Sleep
  reg flag_widle; // Woke from Idle
  reg flag_wdtwake; // Watchdog woke from Sleep
  reg ost_start; // Start the oscillator counter
  wire ost_done; // Start-up count complete
  wire doze_tick; // Divided processor enable
  wire wdt_on; // Watchdog enabled by either control
  wire wake; // Any wake event
  wire acc; // Completing APB access
  wire wr; // Completing APB write
  wire ev_wsleep; // Sleep wake event
  wire ev_widle; // Idle wake event

  assign wdt_on = wdt_en_cfg | swdt;
  assign wake = irq_wake | wdt_timeout;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign ev_wsleep = (state == ST_SLEEP) & wake;
  assign ev_widle = (state == ST_IDLE) & wake;

  // ----------------------------------------
  // Helper blocks
  // ----------------------------------------
  pmcg_doze_div #(.CW(7)) pmcg_doze_div_i
  (
    .pclk(pclk),
    .presetn(presetn),
    .ratio(doze_ratio),
    .tick(doze_tick)
  );

  pmcg_ost #(.COUNT(OST_COUNT)) pmcg_ost_i
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(ost_start),
    .done(ost_done)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      case (paddr)
        `PMCG_OFS_CTRL:
        begin
          prdata[`PMCG_CTRL_RATIO_MSB:`PMCG_CTRL_RATIO_LSB] <= doze_ratio;
          prdata[`PMCG_CTRL_DOZE] <= doze_en;
          prdata[`PMCG_CTRL_SRC_MSB:`PMCG_CTRL_SRC_LSB] <= sw_src;
          prdata[`PMCG_CTRL_SWREQ] <= sw_pend;
          prdata[`PMCG_CTRL_SWDT] <= swdt;
        end
        `PMCG_OFS_STOPIDLE:
          prdata[NPER-1:0] <= stop_idle;
        `PMCG_OFS_STATUS:
        begin
          prdata[`PMCG_STAT_STATE_MSB:`PMCG_STAT_STATE_LSB] <= state;
          prdata[`PMCG_STAT_SRC_MSB:`PMCG_STAT_SRC_LSB] <= clk_src_sel;
          prdata[`PMCG_STAT_WSLEEP] <= flag_wsleep;
          prdata[`PMCG_STAT_WIDLE] <= flag_widle;
          prdata[`PMCG_STAT_WDTWAKE] <= flag_wdtwake;
        end
        // Unmapped address answers with an error and zero data
        default:
          pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software control registers
  // ----------------------------------------
  // Writes land at the edge that completes the access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      doze_ratio <= 3'h0;
      doze_en <= 1'b0;
      sw_src <= `PMCG_SRC_FRC;
      sw_pend <= 1'b0;
      swdt <= 1'b0;
      stop_idle <= {NPER{1'b0}};
    end
    else
    begin
      if (state == ST_SWOFF)
      begin
        sw_pend <= 1'b0; // Request consumed
      end
      if (wr && paddr == `PMCG_OFS_CTRL)
      begin
        doze_ratio <= pwdata[`PMCG_CTRL_RATIO_MSB:`PMCG_CTRL_RATIO_LSB];
        doze_en <= pwdata[`PMCG_CTRL_DOZE];
        swdt <= pwdata[`PMCG_CTRL_SWDT];
        // Non-permissible source codes are ignored
        if (pwdata[`PMCG_CTRL_SWREQ] && src_ok(pwdata[`PMCG_CTRL_SRC_MSB:`PMCG_CTRL_SRC_LSB]))
        begin
          sw_src <= pwdata[`PMCG_CTRL_SRC_MSB:`PMCG_CTRL_SRC_LSB];
          sw_pend <= 1'b1;
        end
      end
      if (wr && paddr == `PMCG_OFS_STOPIDLE)
      begin
        stop_idle <= pwdata[NPER-1:0];
      end
    end
  end

  // ----------------------------------------
  // Wake flags, write one to clear
  // ----------------------------------------
  // A wake in the clearing cycle keeps its flag set
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_wsleep <= 1'b0;
      flag_widle <= 1'b0;
      flag_wdtwake <= 1'b0;
    end
    else
    begin
      flag_wsleep <= ev_wsleep | (flag_wsleep & ~(wr && paddr == `PMCG_OFS_STATUS && pwdata[`PMCG_STAT_WSLEEP]));
      flag_widle <= ev_widle | (flag_widle & ~(wr && paddr == `PMCG_OFS_STATUS && pwdata[`PMCG_STAT_WIDLE]));
      flag_wdtwake <= (ev_wsleep & wdt_timeout)
                      | (flag_wdtwake & ~(wr && paddr == `PMCG_OFS_STATUS && pwdata[`PMCG_STAT_WDTWAKE]));
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        // Only the power-save instruction leads to Sleep or Idle
        if (power_save_instruction_exec && !boot_load)
          next_state = power_save_instruction_idle ? ST_IDLE : ST_SLEEP;
        else if (sw_pend && !boot_load)
          next_state = ST_SWOFF;
      end
      ST_SLEEP:
        if (wake)
          next_state = needs_ost(clk_src_sel) ? ST_OST : ST_RUN;
      ST_IDLE:
        if (wake)
          next_state = ST_RUN;
      ST_OST:
        if (ost_done)
          next_state = ST_RUN;
      ST_SWOFF:
        next_state = needs_ost(sw_src) ? ST_OST : ST_SWON;
      ST_SWON:
        next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // ----------------------------------------
  // State register and source selection
  // ----------------------------------------
  // The source is changed only while every clock is gated off,
  // so no shortened pulse can reach the processor or peripherals
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_RUN;
      boot_load <= 1'b1;
      clk_src_sel <= `PMCG_SRC_FRC;
      ost_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ost_start <= (next_state == ST_OST) && (state != ST_OST);
      if (boot_load)
      begin
        boot_load <= 1'b0;
        clk_src_sel <= src_ok(cfg_clk_src) ? cfg_clk_src : `PMCG_SRC_FRC;
      end
      else if (state == ST_SWOFF)
      begin
        clk_src_sel <= sw_src;
      end
    end
  end

  // ----------------------------------------
  // Clock gating and power outputs
  // ----------------------------------------
  // All enables are flops, so the gating cells see clean levels
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b0;
      periph_clk_en <= {NPER{1'b0}};
      ext_periph_en <= 1'b0;
      osc_en <= 1'b0;
      clock_failure_monitor_active <= 1'b0;
      low_power_rc_clock_run <= 1'b0;
      bor_active <= 1'b0;
      wdt_clear <= 1'b0;
      wdt_reset_req <= 1'b0;
      cpu_resume <= 1'b0;
    end
    else
    begin
      ext_periph_en <= 1'b1;
      bor_active <= bor_en_cfg;
      // Clear the watchdog on the way into either low-power state
      wdt_clear <= wdt_on && state == ST_RUN && (next_state == ST_SLEEP || next_state == ST_IDLE);
      // Timeout outside Sleep resets; in Sleep it only wakes
      wdt_reset_req <= wdt_timeout && state != ST_SLEEP;
      cpu_resume <= ev_widle || (state != ST_RUN && state != ST_IDLE && next_state == ST_RUN
                                 && state != ST_SWON && state != ST_SWOFF);
      case (next_state)
        ST_SLEEP:
        begin
          cpu_clk_en <= 1'b0;
          sys_clk_en <= 1'b0;
          periph_clk_en <= {NPER{1'b0}};
          osc_en <= 1'b0;
          clock_failure_monitor_active <= 1'b0;
          low_power_rc_clock_run <= wdt_on;
        end
        ST_IDLE:
        begin
          cpu_clk_en <= 1'b0;
          sys_clk_en <= 1'b1;
          periph_clk_en <= ~stop_idle;
          osc_en <= 1'b1;
          clock_failure_monitor_active <= clock_failure_monitor_en_cfg;
          low_power_rc_clock_run <= wdt_on | clock_failure_monitor_en_cfg;
        end
        ST_OST, ST_SWOFF, ST_SWON:
        begin
          // Processor, system and peripheral clocks held off while the new source settles
          cpu_clk_en <= 1'b0;
          sys_clk_en <= 1'b0;
          periph_clk_en <= {NPER{1'b0}};
          osc_en <= 1'b1;
          clock_failure_monitor_active <= 1'b0;
          low_power_rc_clock_run <= wdt_on | clock_failure_monitor_en_cfg;
        end
        default:
        begin
          // Run, with Doze slowing only the processor; peripherals
          // keep full rate and processor enables stay on their grid
          cpu_clk_en <= doze_en ? doze_tick : 1'b1;
          sys_clk_en <= 1'b1;
          periph_clk_en <= {NPER{1'b1}};
          osc_en <= 1'b1;
          clock_failure_monitor_active <= clock_failure_monitor_en_cfg;
          low_power_rc_clock_run <= wdt_on | clock_failure_monitor_en_cfg;
        end
      endcase
    end
  end

endmodule // pmcg_top

// ===== dv/pmcg_chk.sv
// Checker for power mode sequencing at the top ports
`timescale 1ns/10ps
module pmcg_chk
#(
  parameter OST_COUNT = 8
)
(
  input wire pclk,
  input wire presetn,
  input wire power_save_instruction_exec,
  input wire power_save_instruction_idle,
  input wire irq_wake,
  input wire wdt_timeout,
  input wire wdt_en_cfg,
  input wire bor_en_cfg,
  input wire cpu_clk_en,
  input wire sys_clk_en,
  input wire osc_en,
  input wire [2:0] clk_src_sel,
  input wire clock_failure_monitor_active,
  input wire low_power_rc_clock_run,
  input wire bor_active,
  input wire wdt_clear,
  input wire wdt_reset_req,
  input wire cpu_resume
);
  // ----------------------------------------
  // Mode tracking
  // ----------------------------------------
  reg in_slp; // Asleep
  reg in_idl; // Idle
  wire wake = irq_wake | wdt_timeout; // Any wake event
  wire run = sys_clk_en & osc_en & ~in_slp & ~in_idl; // Running
  // Follow entries and wakes as seen at the ports
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      in_slp <= 1'b0;
      in_idl <= 1'b0;
    end
    else
    begin
      in_slp <= (run & power_save_instruction_exec & ~power_save_instruction_idle) | (in_slp & ~wake);
      in_idl <= (run & power_save_instruction_exec & power_save_instruction_idle) | (in_idl & ~wake);
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  sequence s_slp;
    run && power_save_instruction_exec && !power_save_instruction_idle;
  endsequence
  sequence s_idl;
    run && power_save_instruction_exec && power_save_instruction_idle;
  endsequence
  a_sleep_gates: assert property (s_slp |=> !sys_clk_en && !osc_en && !cpu_clk_en)
    else $error("sleep entry left a clock running");
  a_clock_failure_monitor_sleep: assert property (in_slp |-> !clock_failure_monitor_active)
    else $error("clock monitor active in sleep");
  a_sleep_wdt: assert property ((s_slp and wdt_en_cfg) |=> wdt_clear && low_power_rc_clock_run)
    else $error("watchdog not cleared or rc clock stopped");
  a_bor_follow: assert property (1'b1 |=> bor_active == $past(bor_en_cfg))
    else $error("brown-out detect does not follow enable");
  a_idle_entry: assert property (s_idl |=> sys_clk_en && !cpu_clk_en && (wdt_clear || !wdt_en_cfg))
    else $error("idle entry wrong");
  a_idle_wake: assert property (in_idl && wake |=> cpu_clk_en && cpu_resume)
    else $error("idle wake not immediate");
  a_sleep_wake: assert property (in_slp && wake |-> ##[1:40] cpu_resume)
    else $error("no resume after sleep wake");
  a_ost_hold: assert property (in_slp && wake && clk_src_sel >= 3'h2 && clk_src_sel <= 3'h4
    |=> !cpu_resume [*8])
    else $error("crystal restart not held back");
  a_wdt_sleep: assert property (in_slp && wdt_timeout |=> !wdt_reset_req)
    else $error("watchdog reset in sleep");
  a_wdt_reset: assert property ((run || in_idl) && wdt_timeout |=> wdt_reset_req)
    else $error("watchdog timeout gave no reset");
endmodule // pmcg_chk
bind pmcg_top pmcg_chk #(.OST_COUNT(OST_COUNT)) pmcg_chk_i (.pclk(pclk), .presetn(presetn),
  .power_save_instruction_exec(power_save_instruction_exec), .power_save_instruction_idle(power_save_instruction_idle), .irq_wake(irq_wake), .wdt_timeout(wdt_timeout),
  .wdt_en_cfg(wdt_en_cfg), .bor_en_cfg(bor_en_cfg), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
  .osc_en(osc_en), .clk_src_sel(clk_src_sel), .clock_failure_monitor_active(clock_failure_monitor_active), .low_power_rc_clock_run(low_power_rc_clock_run),
  .bor_active(bor_active), .wdt_clear(wdt_clear), .wdt_reset_req(wdt_reset_req), .cpu_resume(cpu_resume));

// ===== dv/pmcg_cpu_model.sv
// Processor core stand-in issuing power-save and interrupts
`timescale 1ns/10ps
module pmcg_cpu_model
(
  input wire pclk,
  input wire presetn,
  input wire cpu_clk_en,
  input wire cpu_resume,
  input wire cmd_go,
  input wire cmd_idle,
  input wire [7:0] wake_dly,
  output reg power_save_instruction_exec,
  output reg power_save_instruction_idle,
  output reg irq_wake
);
  reg pend; // Instruction waiting for a tick
  reg [7:0] cnt; // Cycles to the interrupt; zero means none
  // An instruction retires only on a processor tick, so a slowed clock delays it
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pend <= 1'b0;
      power_save_instruction_exec <= 1'b0;
      power_save_instruction_idle <= 1'b0;
      irq_wake <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      power_save_instruction_exec <= pend & cpu_clk_en;
      if (cmd_go)
        pend <= 1'b1;
      else if (cpu_clk_en)
        pend <= 1'b0;
      if (cmd_go)
        power_save_instruction_idle <= cmd_idle;
      if (power_save_instruction_exec)
        cnt <= wake_dly;
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
      // Request held until the core has resumed
      if (cnt == 8'h01)
        irq_wake <= 1'b1;
      else if (cpu_resume)
        irq_wake <= 1'b0;
    end
endmodule // pmcg_cpu_model

// ===== dv/test_power_mode_clock_gating.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
`include "pmcg_defs.vh"
module test_power_mode_clock_gating;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg wdt_timeout = 1'b0;
  reg wdt_en_cfg = 1'b1;
  reg clock_failure_monitor_en_cfg = 1'b1;
  reg bor_en_cfg = 1'b1;
  reg [2:0] cfg_clk_src = `PMCG_SRC_LOW_POWER_RC_CLOCK;
  reg cmd_go = 1'b0;
  reg cmd_idle = 1'b0;
  reg [7:0] wake_dly = 8'h00;
  reg [31:0] rd; // Last read data
  reg er; // Last error response
  wire [31:0] prdata;
  wire pready, pslverr, power_save_instruction_exec, power_save_instruction_idle, irq_wake, cpu_clk_en, sys_clk_en;
  wire ext_periph_en, osc_en, clock_failure_monitor_active, low_power_rc_clock_run, bor_active, wdt_clear, wdt_reset_req, cpu_resume;
  wire [7:0] periph_clk_en;
  wire [2:0] clk_src_sel;
  integer fails = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer rst_seen = 0; // Watchdog reset requests seen
  integer r;
  integer n;
  // Short start-up count keeps the run brief
  pmcg_top #(.NPER(8), .OST_COUNT(8)) pmcg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_save_instruction_exec(power_save_instruction_exec), .power_save_instruction_idle(power_save_instruction_idle), .irq_wake(irq_wake),
    .wdt_timeout(wdt_timeout), .wdt_en_cfg(wdt_en_cfg), .clock_failure_monitor_en_cfg(clock_failure_monitor_en_cfg), .bor_en_cfg(bor_en_cfg),
    .cfg_clk_src(cfg_clk_src), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .periph_clk_en(periph_clk_en), .ext_periph_en(ext_periph_en), .osc_en(osc_en),
    .clk_src_sel(clk_src_sel), .clock_failure_monitor_active(clock_failure_monitor_active), .low_power_rc_clock_run(low_power_rc_clock_run), .bor_active(bor_active),
    .wdt_clear(wdt_clear), .wdt_reset_req(wdt_reset_req), .cpu_resume(cpu_resume));
  pmcg_cpu_model pmcg_cpu_model_i (.pclk(pclk), .presetn(presetn), .cpu_clk_en(cpu_clk_en),
    .cpu_resume(cpu_resume), .cmd_go(cmd_go), .cmd_idle(cmd_idle), .wake_dly(wake_dly),
    .power_save_instruction_exec(power_save_instruction_exec), .power_save_instruction_idle(power_save_instruction_idle), .irq_wake(irq_wake));
  // ----------------------------------------
  // Clock, watchdog monitor, timeout
  // ----------------------------------------
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wdt_reset_req === 1'b1)
      rst_seen <= rst_seen + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One transfer; holds the request until pready is sampled high, only the bench timeout ends the wait
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  // Core runs the power-save instruction; dly zero means no interrupt
  task pws(input idle, input [7:0] dly);
  begin
    cmd_idle <= idle;
    wake_dly <= dly;
    cmd_go <= 1'b1;
    @(posedge pclk);
    cmd_go <= 1'b0;
    repeat (4) @(posedge pclk);
  end
  endtask
  task wait_res;
  begin
    n = 0;
    while (cpu_resume !== 1'b1 && n < 200)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    chk(n < 200, 1);
    @(posedge pclk);
  end
  endtask
  task wdt_pulse;
  begin
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
  end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_boot;
  begin
    apb(0, `PMCG_OFS_STATUS, 0);
    chk(rd[`PMCG_STAT_SRC_MSB:`PMCG_STAT_SRC_LSB], `PMCG_SRC_LOW_POWER_RC_CLOCK);
    apb(0, 12'h00C, 0);
    chk(er, 1);
    chk(rd, 0);
  end
  endtask
  task t_sleep;
  begin
    pws(1'b0, 8'd20);
    chk({sys_clk_en, osc_en, cpu_clk_en, clock_failure_monitor_active}, 0);
    chk({low_power_rc_clock_run, bor_active, ext_periph_en}, 7);
    wait_res;
    chk(cpu_clk_en, 1);
    pws(1'b0, 8'd0);
    wdt_pulse;
    wait_res;
    chk(rst_seen, 0);
    apb(0, `PMCG_OFS_STATUS, 0);
    chk(rd[`PMCG_STAT_WDTWAKE], 1);
  end
  endtask
  task t_idle;
  begin
    wdt_en_cfg <= 1'b0;
    apb(1, `PMCG_OFS_STOPIDLE, 32'hA5);
    pws(1'b1, 8'd20);
    chk({periph_clk_en, sys_clk_en, cpu_clk_en, low_power_rc_clock_run}, 11'h2D5);
    wait_res;
    chk(periph_clk_en, 8'hFF);
    // Watchdog back on so the Idle entry clear is exercised
    wdt_en_cfg <= 1'b1;
    pws(1'b1, 8'd0);
    wdt_pulse;
    wait_res;
    chk(rst_seen > 0, 1);
  end
  endtask
  task t_doze;
  begin
    for (r = 0; r < 8; r = r + 1)
    begin
      apb(1, `PMCG_OFS_CTRL, 32'h8 | r);
      repeat (300) @(posedge pclk);
      n = 0;
      repeat (256)
      begin
        @(posedge pclk);
        n = n + cpu_clk_en;
      end
      chk(n, 256 >> r);
    end
    apb(1, `PMCG_OFS_CTRL, 0);
  end
  endtask
  task t_switch;
  begin
    apb(1, `PMCG_OFS_CTRL, 32'hE0);
    repeat (20) @(posedge pclk);
    chk(clk_src_sel, `PMCG_SRC_LOW_POWER_RC_CLOCK);
    apb(1, `PMCG_OFS_CTRL, 32'hA0);
    repeat (30) if (rd[5:0] !== 6'h10) apb(0, `PMCG_OFS_STATUS, 0);
    chk(rd[5:0], 6'h10);
    pws(1'b0, 8'd20);
    wait_res;
  end
  endtask
  task results;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_boot;
    t_sleep;
    t_idle;
    t_doze;
    t_switch;
    results;
  end
endmodule // test_power_mode_clock_gating
